// ---- hdl/lcr_channel_regs.sv ----
// Per-channel control and status registers of the eight-channel line interface
`timescale 1ns/1ps
module lcr_channel_regs (
   // Host side
   input wire logic core_clk,
   input wire logic rst_n,
   input wire lcr_pkg::lcr_host_req_t host_req,
   output logic [7:0] host_rdata,
   // Device pins
   input wire logic output_enable_n,
   input wire logic clock_edge_select_pin,
   input wire logic pll_input_select,
   input wire logic [7:0] loss_of_signal,
   output logic hitless_impedance_off,
   // Tester and clock steering
   output logic tester_enable,
   output logic [7:0] tester_channel,
   output logic pll_use_master,
   output logic [7:0] pll_source_channel,
   output logic line_rate_clock_select,
   output logic [3:0] auxiliary_clock_code,
   output logic [31:0] auxiliary_clock_hz,
   // Line side, on the line clock
   input wire logic line_clk,
   input wire lcr_pkg::lcr_line_cfg_t line_cfg,
   input wire lcr_pkg::lcr_viol_evt_t viol_evt,
   input wire logic [7:0] rx_dec_pos,
   input wire logic [7:0] rx_dec_neg,
   output logic [7:0] rx_positive_rail,
   output logic [7:0] rx_negative_rail,
   input wire logic [7:0] tx_positive_rail,
   input wire logic [7:0] tx_negative_rail,
   output logic [7:0] tx_pos_sampled,
   output logic [7:0] tx_neg_sampled,
   output logic [7:0] tx_bpv_insert
);

   // ****************************************************************
   // Register file
   // ****************************************************************
   logic [7:0] hitless_protection_control;
   logic [7:0] bert_control;
   logic [7:0] violation_insert;
   logic [7:0] line_violation_status;
   logic [7:0] receive_clock_invert;
   logic [7:0] transmit_clock_invert;
   logic [7:0] clock_control;
   logic status_read;
   logic [7:0] viol_seen;

   assign status_read = host_req.rd && (host_req.addr == lcr_pkg::ADDR_LV_STATUS);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hitless_protection_control <= lcr_pkg::REG_RESET; // RULE_20
         bert_control <= lcr_pkg::REG_RESET;
         violation_insert <= lcr_pkg::REG_RESET;
         receive_clock_invert <= lcr_pkg::REG_RESET;
         transmit_clock_invert <= lcr_pkg::REG_RESET;
         clock_control <= lcr_pkg::REG_RESET;
      end else if (host_req.wr) begin
         case (host_req.addr)
            lcr_pkg::ADDR_HITLESS: hitless_protection_control <= host_req.wdata;
            lcr_pkg::ADDR_BERT_CTRL: bert_control <= host_req.wdata;
            lcr_pkg::ADDR_VIOL_INS: violation_insert <= host_req.wdata;
            lcr_pkg::ADDR_RX_INV: receive_clock_invert <= host_req.wdata;
            lcr_pkg::ADDR_TX_INV: transmit_clock_invert <= host_req.wdata;
            lcr_pkg::ADDR_CLK_CTRL: clock_control <= host_req.wdata;
            default: ;
         endcase
      end
   end

   // Set wins over the read that clears
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         line_violation_status <= lcr_pkg::REG_RESET;
      end else begin
         line_violation_status <= (line_violation_status & ~{8{status_read}}) // RULE_06
                                  | viol_seen; // RULE_05
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_rdata <= lcr_pkg::READ_UNMAPPED;
      end else if (host_req.rd) begin
         case (host_req.addr)
            lcr_pkg::ADDR_HITLESS: host_rdata <= hitless_protection_control;
            lcr_pkg::ADDR_BERT_CTRL: host_rdata <= bert_control;
            lcr_pkg::ADDR_VIOL_INS: host_rdata <= violation_insert;
            lcr_pkg::ADDR_LV_STATUS: host_rdata <= line_violation_status;
            lcr_pkg::ADDR_RX_INV: host_rdata <= receive_clock_invert;
            lcr_pkg::ADDR_TX_INV: host_rdata <= transmit_clock_invert;
            lcr_pkg::ADDR_CLK_CTRL: host_rdata <= clock_control;
            default: host_rdata <= lcr_pkg::READ_UNMAPPED;
         endcase
      end
   end

   // ****************************************************************
   // Pin synchronisers, core side
   // ****************************************************************
   logic [9:0] pins_s;
   logic oe_n_s;
   logic pll_in_s;
   logic [7:0] los_s;

   lcr_sync #(.W(10)) u_pin_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      .d({output_enable_n, pll_input_select, loss_of_signal}),
      .q(pins_s)
   );
   assign oe_n_s = pins_s[9];
   assign pll_in_s = pins_s[8];
   assign los_s = pins_s[7:0];

   // ****************************************************************
   // Static steering
   // ****************************************************************
   logic [2:0] tester_sel;
   logic [2:0] pll_src;

   assign tester_sel = bert_control[lcr_pkg::TESTER_SEL_LSB +: 3];
   assign pll_src = clock_control[lcr_pkg::PLL_SRC_LSB +: 3];

   // Pin-only trigger: output enable low arms it, no edge needed
   assign hitless_impedance_off = hitless_protection_control[lcr_pkg::HITLESS_BIT]
                                  && !oe_n_s; // RULE_01
   assign tester_enable = bert_control[lcr_pkg::TESTER_EN_BIT]; // RULE_03
   assign tester_channel = tester_enable ? lcr_pkg::one_hot(tester_sel) : 8'h00; // RULE_02
   assign pll_source_channel = lcr_pkg::one_hot(pll_src); // RULE_14
   assign pll_use_master = !pll_in_s // RULE_19
                           || ((los_s & pll_source_channel) != 8'h00); // RULE_15
   assign line_rate_clock_select = clock_control[lcr_pkg::RATE_SEL_BIT]; // RULE_16
   assign auxiliary_clock_code = clock_control[lcr_pkg::AUX_SEL_LSB +: 4]; // RULE_17
   assign auxiliary_clock_hz = lcr_pkg::aux_hz(auxiliary_clock_code); // RULE_18

   // ****************************************************************
   // Violation insertion, core to line by toggle
   // ****************************************************************
   logic [7:0] ins_prev;
   logic [7:0] ins_rise;
   logic [7:0] ins_tgl;

   assign ins_rise = violation_insert & ~ins_prev;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ins_prev <= 8'h00;
         ins_tgl <= 8'h00;
      end else begin
         ins_prev <= violation_insert;
         ins_tgl <= ins_tgl ^ ins_rise; // RULE_04
      end
   end

   // ****************************************************************
   // Line domain
   // ****************************************************************
   logic [7:0] ins_tgl_s;
   logic [7:0] ins_tgl_d;
   logic [7:0] rx_inv_s;
   logic [7:0] tx_inv_s;
   logic edge_pin_s;
   logic [31:0] cfg_bits_s;
   lcr_pkg::lcr_line_cfg_t cfg_s;

   lcr_sync #(.W(8)) u_ins_sync (
      .clk(line_clk),
      .rst_n(rst_n),
      .d(ins_tgl),
      .q(ins_tgl_s)
   );
   lcr_sync #(.W(17)) u_inv_sync (
      .clk(line_clk),
      .rst_n(rst_n),
      .d({clock_edge_select_pin, receive_clock_invert, transmit_clock_invert}),
      .q({edge_pin_s, rx_inv_s, tx_inv_s})
   );
   lcr_sync #(.W(32)) u_cfg_sync (
      .clk(line_clk),
      .rst_n(rst_n),
      .d(line_cfg),
      .q(cfg_bits_s)
   );
   assign cfg_s = cfg_bits_s;

   always_ff @(posedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         ins_tgl_d <= 8'h00;
         tx_bpv_insert <= 8'h00;
      end else begin
         ins_tgl_d <= ins_tgl_s;
         tx_bpv_insert <= ins_tgl_s ^ ins_tgl_d; // RULE_04
      end
   end

   // Violation qualifying and three-period hold-off
   logic [7:0] viol_hit;
   logic [7:0] viol_busy;
   logic [1:0] win_cnt [8];
   logic [7:0] viol_tgl;

   assign viol_hit = viol_evt.bpv // RULE_10
      | (~cfg_s.dual_rail_mode & viol_evt.code_viol & cfg_s.hdb3_mode
         & ~cfg_s.code_violation_disable) // RULE_09
      | (~cfg_s.dual_rail_mode & viol_evt.excess_zero
         & cfg_s.excess_zero_detect_enable); // RULE_08

   // The hold-off lives on the line side so a host read cannot reopen it
   always_ff @(posedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         viol_tgl <= 8'h00;
         for (int i = 0; i < 8; i++) begin
            win_cnt[i] <= 2'h0;
         end
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (win_cnt[i] != 2'h0) begin
               win_cnt[i] <= win_cnt[i] - 2'h1; // RULE_07
            end else if (viol_hit[i]) begin
               win_cnt[i] <= lcr_pkg::VIOL_WINDOW_CLKS - 2'h1;
               viol_tgl[i] <= ~viol_tgl[i]; // RULE_05
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         viol_busy[i] = (win_cnt[i] != 2'h0);
      end
   end

   // Back into the core domain
   logic [7:0] viol_tgl_s;
   logic [7:0] viol_tgl_d;

   lcr_sync #(.W(8)) u_viol_sync (
      .clk(core_clk),
      .rst_n(rst_n),
      .d(viol_tgl),
      .q(viol_tgl_s)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         viol_tgl_d <= 8'h00;
      end else begin
         viol_tgl_d <= viol_tgl_s;
      end
   end
   assign viol_seen = viol_tgl_s ^ viol_tgl_d;

   // ****************************************************************
   // Receive rails: rising or falling edge launch
   // ****************************************************************
   logic [7:0] rx_pos_rise;
   logic [7:0] rx_neg_rise;
   logic [7:0] rx_pos_fall;
   logic [7:0] rx_neg_fall;
   logic [7:0] rx_on_fall;

   assign rx_on_fall = rx_inv_s | {8{edge_pin_s}}; // RULE_11 RULE_12

   always_ff @(posedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_pos_rise <= 8'h00;
         rx_neg_rise <= 8'h00;
      end else begin
         rx_pos_rise <= rx_dec_pos;
         rx_neg_rise <= rx_dec_neg;
      end
   end

   // Half a period later, so the rails change on the falling edge
   always_ff @(negedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_pos_fall <= 8'h00;
         rx_neg_fall <= 8'h00;
      end else begin
         rx_pos_fall <= rx_pos_rise;
         rx_neg_fall <= rx_neg_rise;
      end
   end

   assign rx_positive_rail = (rx_on_fall & rx_pos_fall) | (~rx_on_fall & rx_pos_rise);
   assign rx_negative_rail = (rx_on_fall & rx_neg_fall) | (~rx_on_fall & rx_neg_rise);

   // ****************************************************************
   // Transmit rails: sample on the edge opposite to the launch edge
   // ****************************************************************
   logic [7:0] tx_pos_at_rise;
   logic [7:0] tx_neg_at_rise;
   logic [7:0] tx_pos_at_fall;
   logic [7:0] tx_neg_at_fall;

   always_ff @(posedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pos_at_rise <= 8'h00;
         tx_neg_at_rise <= 8'h00;
         tx_pos_sampled <= 8'h00;
         tx_neg_sampled <= 8'h00;
      end else begin
         tx_pos_at_rise <= tx_positive_rail;
         tx_neg_at_rise <= tx_negative_rail;
         tx_pos_sampled <= (tx_inv_s & tx_pos_at_fall) | (~tx_inv_s & tx_pos_at_rise); // RULE_13
         tx_neg_sampled <= (tx_inv_s & tx_neg_at_fall) | (~tx_inv_s & tx_neg_at_rise); // RULE_13
      end
   end

   always_ff @(negedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pos_at_fall <= 8'h00;
         tx_neg_at_fall <= 8'h00;
      end else begin
         tx_pos_at_fall <= tx_positive_rail;
         tx_neg_at_fall <= tx_negative_rail;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_status_read_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_06
      (status_read && viol_seen == 8'h00) |=> line_violation_status == 8'h00)
      else $error("status not cleared by read");

   a_status_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_05
      (viol_seen != 8'h00) |=> (line_violation_status & $past(viol_seen)) == $past(viol_seen))
      else $error("violation lost in status");

   a_insert_one_toggle: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_04
      (ins_tgl ^ $past(ins_tgl)) == ($past(violation_insert) & ~$past(violation_insert, 2)))
      else $error("insert toggle does not follow rising bit");

   a_insert_single_pulse: assert property (@(posedge line_clk) disable iff (!rst_n) // RULE_04
      (tx_bpv_insert != 8'h00) |=> tx_bpv_insert == 8'h00)
      else $error("insert pulse longer than one cycle");

   a_window_hold_off: assert property (@(posedge line_clk) disable iff (!rst_n) // RULE_07
      ##1 ((viol_tgl ^ $past(viol_tgl)) & $past(viol_busy)) == 8'h00)
      else $error("violation latched inside hold-off window");

   a_dual_rail_only: assert property (@(posedge line_clk) disable iff (!rst_n) // RULE_10
      (viol_hit & cfg_s.dual_rail_mode & ~viol_evt.bpv) == 8'h00)
      else $error("non-bipolar violation counted in dual-rail mode");

   a_pll_fallback: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_15
      (pll_in_s && los_s[pll_src]) |-> pll_use_master)
      else $error("PLL not on master clock during loss");

   a_tester_select: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_02
      (host_req.wr && host_req.addr == lcr_pkg::ADDR_BERT_CTRL) |=>
      tester_channel == ($past(host_req.wdata[0]) ? 8'h01 << $past(host_req.wdata[7:5]) : 8'h00))
      else $error("tester channel wrong after write");

   a_hitless_pin: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE_01
      (!$past(output_enable_n, 2) && hitless_protection_control[0]) |-> hitless_impedance_off)
      else $error("impedance matching not turned off");

   c_insert: cover property (@(posedge line_clk) disable iff (!rst_n) tx_bpv_insert != 8'h00);
   c_status_read: cover property (@(posedge core_clk) disable iff (!rst_n)
      status_read && line_violation_status != 8'h00);
   c_pll_fallback: cover property (@(posedge core_clk) disable iff (!rst_n)
      pll_in_s && pll_use_master);

endmodule // lcr_channel_regs

// ---- hdl/lcr_pkg.sv ----
// Constants, types and helper functions for the line channel control registers
// Function
// RULE_01: Hitless bit set and output-enable pin low turns off receive impedance matching.
// RULE_02: Tester channel field, bits 7..5, picks the tester's channel only while enabled.
// RULE_03: Tester enable bit activates the one shared tester, one channel at a time.
// RULE_04: Each 0-to-1 of an insertion bit inserts exactly one bipolar violation.
// RULE_05: Status bit latches on bipolar, code or excessive-zeros violation of its channel.
// RULE_06: Reading the status register clears its bits.
// RULE_07: Only the first violation in a three-clock window latches, reads notwithstanding.
// RULE_08: Excessive zeros count only with excessive-zeros detection enabled.
// RULE_09: Code violations count only in HDB3 mode and not when disabled.
// RULE_10: In dual-rail mode only bipolar violations set the status bit.
// RULE_11: Receive invert bit moves receive rail changes to the recovered clock's falling edge.
// RULE_12: Clock-edge select pin high forces falling-edge receive rails for every channel.
// RULE_13: Transmit invert bit set means rails align to rising edge, else falling.
// RULE_14: PLL source field, bits 7..5, picks recovered clock of channel code+1.
// RULE_15: Loss of signal on the source channel falls the PLL back to master clock.
// RULE_16: Rate select bit gives 2.048 MHz when set, 1.544 MHz when clear.
// RULE_17: Clock control bits 3..0 choose the auxiliary clock output frequency.
// RULE_18: Auxiliary codes map to 2.048M, 1.544M, 1.536M multiples and 32k..256k.
// RULE_19: PLL input select 0 uses master clock, 1 the chosen recovered clock.
// RULE_20: Bit k of each per-channel register is channel k+1; all reset to zero.
package lcr_pkg;

   localparam int NCH = 8;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_HITLESS = 8'h0F;
   localparam logic [7:0] ADDR_BERT_CTRL = 8'h10;
   localparam logic [7:0] ADDR_VIOL_INS = 8'h11;
   localparam logic [7:0] ADDR_LV_STATUS = 8'h12;
   localparam logic [7:0] ADDR_RX_INV = 8'h13;
   localparam logic [7:0] ADDR_TX_INV = 8'h14;
   localparam logic [7:0] ADDR_CLK_CTRL = 8'h15;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int HITLESS_BIT = 0;
   localparam int TESTER_EN_BIT = 0;
   localparam int TESTER_SEL_LSB = 5;
   localparam int PLL_SRC_LSB = 5;
   localparam int RATE_SEL_BIT = 4;
   localparam int AUX_SEL_LSB = 0;

   // ****************************************************************
   // Timing and frequencies
   // ****************************************************************
   localparam logic [1:0] VIOL_WINDOW_CLKS = 2'h3;
   localparam logic [31:0] HZ_E1 = 32'h001F_4000;
   localparam logic [31:0] HZ_T1 = 32'h0017_8F40;
   localparam logic [31:0] HZ_J = 32'h0017_7000;
   localparam logic [31:0] HZ_LOW = 32'h0000_7D00;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lcr_host_req_t;

   typedef struct packed {
      logic [NCH-1:0] excess_zero_detect_enable;
      logic [NCH-1:0] code_violation_disable;
      logic [NCH-1:0] hdb3_mode;
      logic [NCH-1:0] dual_rail_mode;
   } lcr_line_cfg_t;

   typedef struct packed {
      logic [NCH-1:0] bpv;
      logic [NCH-1:0] code_viol;
      logic [NCH-1:0] excess_zero;
   } lcr_viol_evt_t;

   function automatic logic [NCH-1:0] one_hot(input logic [2:0] sel);
      one_hot = 8'h01 << sel;
   endfunction

   // Auxiliary clock frequency in Hz for a four-bit code
   function automatic logic [31:0] aux_hz(input logic [3:0] code);
      logic [31:0] base;
      base = HZ_E1;
      case (code[3:2])
         2'h0: base = HZ_E1;
         2'h1: base = HZ_T1;
         2'h2: base = HZ_J;
         default: base = HZ_LOW;
      endcase
      aux_hz = base << code[1:0];
   endfunction

endpackage

// ---- hdl/lcr_sync.sv ----
// Two-stage synchroniser for a vector of levels
`timescale 1ns/1ps
module lcr_sync #(
   parameter int W = 8
) (
   // Clock and reset of the receiving domain
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] stage1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= '0;
         q <= '0;
      end else begin
         stage1 <= d;
         q <= stage1;
      end
   end

endmodule // lcr_sync

// ---- verification/lcr_framer_model.sv ----
// Framer-side model: violation events, decoder data and transmit rails
`timescale 1ns/1ps
module lcr_framer_model (
   // Clock and reset
   input wire logic line_clk,
   input wire logic rst_n,
   // Transmit invert setting as programmed by the host
   input wire logic [7:0] tx_inv,
   // Toward the block
   output lcr_pkg::lcr_viol_evt_t viol_evt,
   output logic [7:0] rx_dec_pos,
   output logic [7:0] rx_dec_neg,
   output logic [7:0] tx_positive_rail,
   output logic [7:0] tx_negative_rail
);
   logic rise_q;
   logic fall_q;

   // One line-clock pulse, launched just after a rising edge
   task automatic fire(input lcr_pkg::lcr_viol_evt_t e);
      @(posedge line_clk);
      #1 viol_evt = e;
      @(posedge line_clk);
      #1 viol_evt = '0;
   endtask

   initial viol_evt = '0;

   always @(posedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         rise_q <= 1'b0;
      end else begin
         rise_q <= ~rise_q;
      end
   end

   always @(negedge line_clk or negedge rst_n) begin
      if (!rst_n) begin
         fall_q <= 1'b0;
      end else begin
         fall_q <= ~fall_q;
      end
   end

   // Toggles every cycle so each launch edge of the block is visible
   assign rx_dec_pos = {8{rise_q}};
   assign rx_dec_neg = ~rx_dec_pos;
   // Invert set: rails aligned to the rising edge, else to the falling edge
   assign tx_positive_rail = (tx_inv & {8{rise_q}}) | (~tx_inv & {8{fall_q}});
   assign tx_negative_rail = ~tx_positive_rail;
endmodule // lcr_framer_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the line channel control registers
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic line_clk = 1'b0;
   logic rst_n = 1'b0;
   lcr_pkg::lcr_host_req_t host_req = '0;
   lcr_pkg::lcr_line_cfg_t line_cfg = '0;
   lcr_pkg::lcr_viol_evt_t viol_evt;
   logic output_enable_n = 1'b1;
   logic clock_edge_select_pin = 1'b0;
   logic pll_input_select = 1'b0;
   logic [7:0] loss_of_signal = 8'h00;
   logic [7:0] tx_inv = 8'h00;
   logic [7:0] host_rdata, tester_channel, pll_source_channel, rx_dec_pos, rx_dec_neg;
   logic [7:0] rx_positive_rail, rx_negative_rail, tx_positive_rail, tx_negative_rail;
   logic [7:0] tx_pos_sampled, tx_neg_sampled, tx_bpv_insert;
   logic hitless_impedance_off, tester_enable, pll_use_master, line_rate_clock_select;
   logic [3:0] auxiliary_clock_code;
   logic [31:0] auxiliary_clock_hz;
   logic rx_chk = 1'b0;
   logic rx_lvl = 1'b0;
   logic tx_chk = 1'b0;
   int error_cnt = 0;
   int n_compared = 0;
   int bpv_cnt = 0;
   // addr, write data, read-back value
   localparam logic [23:0] ROWS [7] = '{24'h0F_01_01, 24'h10_A1_A1, 24'h13_5A_5A,
      24'h14_C3_C3, 24'h15_9C_9C, 24'h12_FF_00, 24'h20_FF_00};
   // line config, event, expected status
   localparam logic [63:0] VROWS [8] = '{
      {32'h0000_0000, 24'h01_00_00, 8'h01}, {32'h0000_0000, 24'h00_00_02, 8'h00},
      {32'h0200_0000, 24'h00_00_02, 8'h02}, {32'h0000_0400, 24'h00_04_00, 8'h04},
      {32'h0004_0400, 24'h00_04_00, 8'h00}, {32'h0000_0000, 24'h00_04_00, 8'h00},
      {32'h0800_0808, 24'h00_08_08, 8'h00}, {32'h0800_0808, 24'h08_00_00, 8'h08}};

   always #12.5 core_clk = ~core_clk;
   always #3 line_clk = ~line_clk;

   lcr_channel_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .host_req(host_req),
      .host_rdata(host_rdata), .output_enable_n(output_enable_n),
      .clock_edge_select_pin(clock_edge_select_pin), .pll_input_select(pll_input_select),
      .loss_of_signal(loss_of_signal), .hitless_impedance_off(hitless_impedance_off),
      .tester_enable(tester_enable), .tester_channel(tester_channel),
      .pll_use_master(pll_use_master), .pll_source_channel(pll_source_channel),
      .line_rate_clock_select(line_rate_clock_select),
      .auxiliary_clock_code(auxiliary_clock_code), .auxiliary_clock_hz(auxiliary_clock_hz),
      .line_clk(line_clk), .line_cfg(line_cfg), .viol_evt(viol_evt),
      .rx_dec_pos(rx_dec_pos), .rx_dec_neg(rx_dec_neg), .rx_positive_rail(rx_positive_rail),
      .rx_negative_rail(rx_negative_rail), .tx_positive_rail(tx_positive_rail),
      .tx_negative_rail(tx_negative_rail), .tx_pos_sampled(tx_pos_sampled),
      .tx_neg_sampled(tx_neg_sampled), .tx_bpv_insert(tx_bpv_insert));

   lcr_framer_model i_far (.line_clk(line_clk), .rst_n(rst_n), .tx_inv(tx_inv),
      .viol_evt(viol_evt), .rx_dec_pos(rx_dec_pos), .rx_dec_neg(rx_dec_neg),
      .tx_positive_rail(tx_positive_rail), .tx_negative_rail(tx_negative_rail));

   // ****
   // Helpers
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Strobe for one edge, then an idle edge before the next request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      cyc(1);
      host_req = '0;
      cyc(1);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      cyc(1);
      host_req = '0;
      chk({24'h0, host_rdata}, {24'h0, e}, what);
      cyc(1);
   endtask
   function automatic logic [31:0] hz(input logic [3:0] c);
      logic [31:0] b;
      case (c[3:2])
         2'h0: b = 32'h001F_4000;
         2'h1: b = 32'h0017_8F40;
         2'h2: b = 32'h0017_7000;
         default: b = 32'h0000_7D00;
      endcase
      return b << c[1:0];
   endfunction
   task automatic stop_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Mid-cycle, so the one-cycle pulse is counted once
   always @(negedge line_clk) if (tx_bpv_insert[0]) bpv_cnt++;
   always @(rx_positive_rail[0]) begin
      if (rx_chk) chk({31'h0, line_clk}, {31'h0, rx_lvl}, "rx edge");
   end
   // Wrong sampling edge shows up as equal, not inverted, rails on channels with the transmit invert bit set
   always @(posedge line_clk) begin
      #1;
      if (tx_chk) chk({8'h0, tx_pos_sampled, tx_neg_sampled, rx_negative_rail},
         {8'h0, ~tx_positive_rail, ~tx_negative_rail, ~rx_positive_rail}, "rail align");
   end

   initial begin
      #200000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end

   // ****
   // Main sequence
   // ****
   initial begin
      logic [7:0] d;
      repeat (4) @(posedge core_clk);
      #1 rst_n = 1'b1;
      cyc(1);
      for (int i = 0; i < 7; i++) rdchk(8'h0F + 8'(i), 8'h00, "reset value");
      chk({31'h0, pll_use_master}, 32'h1, "master at reset");
      foreach (ROWS[i]) begin
         wr(ROWS[i][23:16], ROWS[i][15:8]);
         rdchk(ROWS[i][23:16], ROWS[i][7:0], "readback");
      end
      tx_inv = 8'hC3;
      chk({31'h0, tester_enable}, 32'h1, "tester on");
      chk({24'h0, tester_channel}, 32'h20, "tester chan");
      wr(8'h10, 8'hA0);
      chk({24'h0, tester_channel}, 32'h0, "tester off");
      tx_chk = 1'b1;
      output_enable_n = 1'b0;
      cyc(4);
      chk({31'h0, hitless_impedance_off}, 32'h1, "hitless on");
      output_enable_n = 1'b1;
      cyc(4);
      chk({31'h0, hitless_impedance_off}, 32'h0, "hitless off");
      pll_input_select = 1'b1;
      for (int i = 0; i < 16; i++) begin
         d = {i[2:0], i[0], i[3:0]};
         loss_of_signal = (i >= 8) ? (8'h01 << i[2:0]) : 8'h00;
         wr(8'h15, d);
         cyc(4);
         chk({28'h0, auxiliary_clock_code}, {28'h0, i[3:0]}, "aux code");
         chk(auxiliary_clock_hz, hz(i[3:0]), "aux freq");
         chk({31'h0, line_rate_clock_select}, {31'h0, i[0]}, "rate");
         chk({24'h0, pll_source_channel}, {24'h0, 8'h01 << i[2:0]}, "pll src");
         chk({31'h0, pll_use_master}, {31'h0, i >= 8}, "pll fallback");
      end
      loss_of_signal = 8'h00;
      cyc(4);
      chk({31'h0, pll_use_master}, 32'h0, "pll return");
      pll_input_select = 1'b0;
      cyc(4);
      chk({31'h0, pll_use_master}, 32'h1, "pll master");
      bpv_cnt = 0;
      for (int i = 0; i < 4; i++) begin
         wr(8'h11, {7'h0, i != 2});
         cyc(10);
         chk(bpv_cnt, (i == 3) ? 2 : 1, "insertions");
      end
      foreach (VROWS[i]) begin
         line_cfg = VROWS[i][63:32];
         cyc(2);
         i_far.fire(VROWS[i][31:8]);
         cyc(12);
         rdchk(8'h12, VROWS[i][7:0], "status");
         rdchk(8'h12, 8'h00, "read clear");
      end
      // Second event two line clocks after the first falls inside the window
      i_far.fire('{bpv: 8'h10, code_viol: 8'h00, excess_zero: 8'h00});
      i_far.fire('{bpv: 8'h10, code_viol: 8'h00, excess_zero: 8'h00});
      cyc(12);
      rdchk(8'h12, 8'h10, "window first");
      rdchk(8'h12, 8'h00, "window second");
      for (int i = 0; i < 3; i++) begin
         rx_chk = 1'b0;
         wr(8'h13, {7'h0, i == 1});
         clock_edge_select_pin = (i == 2);
         cyc(4);
         rx_lvl = (i == 0);
         rx_chk = 1'b1;
         cyc(4);
      end
      rx_chk = 1'b0;
      stop_test();
   end
endmodule // tb_top
